//--- ds1_rx_pkg.sv
// Constants, register map and types of the receive backplane output port
package ds1_rx_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] SLIP_BUFFER_CONTROL_ADDR = 8'h16;
  localparam logic [ADDR_W-1:0] RECEIVE_INTERFACE_CONTROL_ADDR = 8'h22;
  localparam logic [ADDR_W-1:0] FIFO_LATENCY_SETTING_ADDR = 8'h24;
  localparam logic [ADDR_W-1:0] EVENT_STATUS_ADDR = 8'h30;
  localparam logic [ADDR_W-1:0] EVENT_MASK_ADDR = 8'h31;
  localparam logic [DATA_W-1:0] SLIP_BUFFER_CONTROL_RST = 8'h00;
  localparam logic [DATA_W-1:0] RECEIVE_INTERFACE_CONTROL_RST = 8'h00;
  localparam logic [DATA_W-1:0] FIFO_LATENCY_SETTING_RST = 8'h60;
  localparam logic [DATA_W-1:0] EVENT_MASK_RST = 8'h00;
  localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
  // Field positions
  localparam int SB_ENABLE_LSB = 0;
  localparam int SB_SYNC_DIR_BIT = 2;
  localparam int RI_CLK_INV_BIT = 3;
  // Event status bits
  localparam int EV_REPEAT_BIT = 0;
  localparam int EV_DELETE_BIT = 1;
  localparam int EV_ALIGN_BIT = 2;
  localparam int EV_FIFO_LOST_BIT = 3;
  localparam int EV_COUNT = 4;
  // Pin inputs, index into the synchroniser vector
  localparam int PIN_LCLK = 0;
  localparam int PIN_LDAT = 1;
  localparam int PIN_LFRM = 2;
  localparam int PIN_BCLK = 3;
  localparam int PIN_FSYNC = 4;
  localparam int PIN_COUNT = 5;
  typedef enum logic [1:0] {
    MODE_BYPASS = 2'h0,
    MODE_ELASTIC = 2'h1,
    MODE_FIFO = 2'h2,
    MODE_BYPASS_ALT = 2'h3
  } sb_mode_t;
  typedef enum logic [2:0] {
    RD_IDLE = 3'h1,
    RD_FILL = 3'h2,
    RD_RUN = 3'h4
  } rd_state_t;
endpackage

//--- ds1_rx_backplane_output.sv
// Receive backplane output port with two-frame slip buffer
//
// Design decision made here: the plain strobed port.
`timescale 1ns/10ps
// How it works
// - Serial rate follows the supplied clock
// - Serial payload data pin is an output
// - Clock inversion bit picks data change edge
// - Frame sync: input marks start, output end
// - Multiframe sync always output, marks end
// - Two-frame buffer, 386 of 512 bits used, can be bypassed
// - Enable 00 or 11: bypass, clock output
// - Enable 01: elastic store, clock input
// - Enable 10: FIFO with programmed latency
// - Sync direction bit sets pin direction
// - Bypass: data and clock from line clock
// - Bypass forces frame sync pin to output
// - Elastic store written on line clock
// - Line in, framer through, serial out
// - Empty read repeats a frame, flags it
// - Full write deletes a frame, flags it
// - FIFO keeps fixed latency, clocks locked
module ds1_rx_backplane_output
  import ds1_rx_pkg::*;
#(
  parameter int FRAME_BITS = 193,
  parameter int MF_FRAMES = 12,
  parameter int BUF_BITS = 512
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic nrst_i,
  // Register port
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [DATA_W-1:0] rdata_o,
  output logic irq_o,
  // Framer side, recovered line timing
  input wire logic recovered_clk_i,
  input wire logic framer_data_i,
  input wire logic framer_frame_i,
  // Backplane pins
  input wire logic rx_backplane_clock_pin_i,
  output logic rx_backplane_clock_pin_o,
  output logic rx_backplane_clock_pin_oe_o,
  input wire logic rx_frame_sync_pin_i,
  output logic rx_frame_sync_pin_o,
  output logic rx_frame_sync_pin_oe_o,
  output logic rx_multiframe_sync_pin_o,
  output logic rx_payload_serial_out_o
);
  localparam int DEPTH = 2 * FRAME_BITS;
  localparam int PW = $clog2(BUF_BITS);
  localparam int BW = $clog2(FRAME_BITS);
  localparam int FW = (MF_FRAMES > 1) ? $clog2(MF_FRAMES) : 1;
  localparam logic [PW-1:0] PTR_ZERO = '0;
  localparam logic [BW-1:0] BIT_LAST = BW'(FRAME_BITS - 1);
  localparam logic [FW-1:0] FRM_LAST = FW'(MF_FRAMES - 1);
  localparam logic [PW-1:0] FILL_FULL = PW'(DEPTH - 1);

  if (DEPTH > BUF_BITS) begin : g_bad_size
    $error("Two frames do not fit the buffer");
  end
  if (FRAME_BITS < 2) begin : g_bad_frame
    $error("A frame needs at least two bits");
  end
  if (MF_FRAMES < 1) begin : g_bad_multiframe
    $error("A multiframe needs at least one frame");
  end
  // A latency beyond the buffer would leave the reader filling for ever
  if ((2 ** DATA_W) > DEPTH) begin : g_bad_latency
    $error("Latency setting can exceed the buffer");
  end

  // Pointer arithmetic modulo the two-frame depth
  function automatic logic [PW-1:0] ptr_add(input logic [PW-1:0] p, input int unsigned d);
    int unsigned s;
    s = p + d;
    if (s >= DEPTH) begin
      s = s - DEPTH;
    end
    return PW'(s);
  endfunction

  function automatic logic is_bypass(input logic [1:0] m);
    return (m == MODE_BYPASS) || (m == MODE_BYPASS_ALT);
  endfunction

  // Registers
  logic [DATA_W-1:0] slip_buffer_control_reg;
  logic [DATA_W-1:0] receive_interface_control_reg;
  logic [DATA_W-1:0] fifo_latency_setting_reg;
  logic [EV_COUNT-1:0] status_reg;
  logic [EV_COUNT-1:0] mask_reg;
  logic [EV_COUNT-1:0] status_next;
  logic [EV_COUNT-1:0] events;

  // Synchronisers
  logic [PIN_COUNT-1:0] pins;
  logic [PIN_COUNT-1:0] s1_reg;
  logic [PIN_COUNT-1:0] s2_reg;
  logic [PIN_COUNT-1:0] s3_reg;
  logic [PIN_COUNT-1:0] filt_reg;
  logic [PIN_COUNT-1:0] prev_reg;

  // Buffer and pointers
  logic buf_mem [BUF_BITS];
  logic [PW-1:0] wr_ptr_reg;
  logic [PW-1:0] rd_ptr_reg;
  logic [PW-1:0] fill;
  logic bypass_bit_reg;
  rd_state_t rd_state_reg;
  logic [1:0] mode_seen_reg;
  logic [BW-1:0] bit_cnt_reg;
  logic [BW-1:0] bit_next;
  logic [FW-1:0] frm_cnt_reg;
  logic align_pend_reg;

  logic [1:0] mode;
  logic bypass;
  logic sync_in;
  logic clk_inv;
  logic lclk_rise;
  logic lfrm_rise;
  logic fsync_rise;
  logic rclk_now;
  logic rclk_was;
  logic change_edge;
  logic wr_en;
  logic fifo_lost;

  assign mode = slip_buffer_control_reg[SB_ENABLE_LSB +: 2];
  assign bypass = is_bypass(mode);
  assign sync_in = ~bypass & slip_buffer_control_reg[SB_SYNC_DIR_BIT];
  assign clk_inv = receive_interface_control_reg[RI_CLK_INV_BIT];
  assign pins = {rx_frame_sync_pin_i, rx_backplane_clock_pin_i, framer_frame_i,
                 framer_data_i, recovered_clk_i};

  // Three-stage synchroniser, a change counts when stages two and three agree
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      filt_reg <= '0;
      prev_reg <= '0;
    end else begin
      s1_reg <= pins;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      filt_reg <= (s2_reg & ~(s2_reg ^ s3_reg)) | (filt_reg & (s2_reg ^ s3_reg));
      prev_reg <= filt_reg;
    end
  end

  assign lclk_rise = filt_reg[PIN_LCLK] & ~prev_reg[PIN_LCLK];
  assign lfrm_rise = filt_reg[PIN_LFRM] & ~prev_reg[PIN_LFRM];
  assign fsync_rise = filt_reg[PIN_FSYNC] & ~prev_reg[PIN_FSYNC];
  // Read timing: line clock in bypass, supplied clock otherwise
  assign rclk_now = bypass ? filt_reg[PIN_LCLK] : filt_reg[PIN_BCLK];
  assign rclk_was = bypass ? prev_reg[PIN_LCLK] : prev_reg[PIN_BCLK];
  assign change_edge = clk_inv ? (~rclk_now & rclk_was) : (rclk_now & ~rclk_was);
  assign wr_en = lclk_rise & ~bypass;
  assign fill = ptr_add(wr_ptr_reg, DEPTH - int'(rd_ptr_reg));
  assign bit_next = (align_pend_reg || bit_cnt_reg == BIT_LAST) ? '0 : bit_cnt_reg + 1'b1;
  assign fifo_lost = (rd_state_reg == RD_RUN) && (mode == MODE_FIFO) &&
                     ((fill == PTR_ZERO) || (fill == FILL_FULL));

  always_comb begin
    events = '0;
    events[EV_REPEAT_BIT] = change_edge && rd_state_reg == RD_RUN && mode == MODE_ELASTIC &&
                            fill == PTR_ZERO;
    events[EV_DELETE_BIT] = wr_en && mode == MODE_ELASTIC && fill == FILL_FULL;
    events[EV_ALIGN_BIT] = change_edge && align_pend_reg && bit_cnt_reg != BIT_LAST;
    events[EV_FIFO_LOST_BIT] = fifo_lost;
  end

  // Write side: line data into the buffer on the recovered clock
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wr_ptr_reg <= '0;
      bypass_bit_reg <= 1'b0;
    end else if (lclk_rise) begin
      bypass_bit_reg <= filt_reg[PIN_LDAT];
      if (wr_en) begin
        if (events[EV_DELETE_BIT]) begin
          wr_ptr_reg <= ptr_add(wr_ptr_reg, DEPTH + 1 - FRAME_BITS);
        end else begin
          wr_ptr_reg <= ptr_add(wr_ptr_reg, 1);
        end
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (wr_en) begin
      buf_mem[wr_ptr_reg] <= filt_reg[PIN_LDAT];
    end
  end

  // Read side state: re-centred whenever the mode changes
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rd_state_reg <= RD_IDLE;
      mode_seen_reg <= MODE_BYPASS;
      rd_ptr_reg <= '0;
    end else begin
      mode_seen_reg <= mode;
      if (bypass) begin
        rd_state_reg <= RD_IDLE;
      end else if (mode != mode_seen_reg || rd_state_reg == RD_IDLE) begin
        if (mode == MODE_ELASTIC) begin
          // Start one frame behind the writer for most slip margin
          rd_state_reg <= RD_RUN;
          rd_ptr_reg <= ptr_add(wr_ptr_reg, DEPTH - FRAME_BITS);
        end else begin
          rd_state_reg <= RD_FILL;
          rd_ptr_reg <= wr_ptr_reg;
        end
      end else begin
        unique case (rd_state_reg)
          RD_IDLE: begin
            rd_state_reg <= RD_IDLE;
          end
          RD_FILL: begin
            if (fill >= PW'(fifo_latency_setting_reg)) begin
              rd_state_reg <= RD_RUN;
            end
          end
          RD_RUN: begin
            if (fifo_lost) begin
              // Clocks drifted apart: refill to the programmed latency
              rd_state_reg <= RD_FILL;
              rd_ptr_reg <= wr_ptr_reg;
            end else if (change_edge) begin
              if (events[EV_REPEAT_BIT]) begin
                rd_ptr_reg <= ptr_add(rd_ptr_reg, DEPTH + 1 - FRAME_BITS);
              end else begin
                rd_ptr_reg <= ptr_add(rd_ptr_reg, 1);
              end
            end
          end
        endcase
      end
    end
  end

  // Serial data out on the selected edge of the serial clock
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rx_payload_serial_out_o <= 1'b0;
    end else if (change_edge) begin
      unique case (rd_state_reg)
        RD_IDLE: begin
          // Falling edge sends the bit latched mid-bit, rising the one sampled now
          if (clk_inv) begin
            rx_payload_serial_out_o <= bypass_bit_reg;
          end else begin
            rx_payload_serial_out_o <= filt_reg[PIN_LDAT];
          end
        end
        RD_FILL: rx_payload_serial_out_o <= 1'b0;
        RD_RUN: begin
          if (events[EV_REPEAT_BIT]) begin
            rx_payload_serial_out_o <= buf_mem[ptr_add(rd_ptr_reg, DEPTH - FRAME_BITS)];
          end else begin
            rx_payload_serial_out_o <= buf_mem[rd_ptr_reg];
          end
        end
      endcase
    end
  end

  // Frame alignment: framer marker in bypass, sync pin when it is an input
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      align_pend_reg <= 1'b0;
    end else if ((sync_in && fsync_rise) || (bypass && lfrm_rise)) begin
      align_pend_reg <= 1'b1;
    end else if (change_edge) begin
      align_pend_reg <= 1'b0;
    end
  end

  // Frame and multiframe counters with end-of-frame pulses
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bit_cnt_reg <= '0;
      frm_cnt_reg <= '0;
      rx_frame_sync_pin_o <= 1'b0;
      rx_multiframe_sync_pin_o <= 1'b0;
    end else if (change_edge) begin
      bit_cnt_reg <= bit_next;
      // A frame is counted only at its natural end, not when a realignment cuts it short
      if (bit_cnt_reg == BIT_LAST) begin
        frm_cnt_reg <= (frm_cnt_reg == FRM_LAST) ? '0 : frm_cnt_reg + 1'b1;
      end
      rx_frame_sync_pin_o <= (bit_next == BIT_LAST);
      rx_multiframe_sync_pin_o <= (bit_next == BIT_LAST) && (frm_cnt_reg == FRM_LAST);
    end
  end

  // Pin directions and the regenerated serial clock
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rx_backplane_clock_pin_o <= 1'b0;
      rx_backplane_clock_pin_oe_o <= 1'b1;
      rx_frame_sync_pin_oe_o <= 1'b1;
    end else begin
      rx_backplane_clock_pin_o <= filt_reg[PIN_LCLK];
      rx_backplane_clock_pin_oe_o <= bypass;
      rx_frame_sync_pin_oe_o <= ~sync_in;
    end
  end

  // Control registers
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      slip_buffer_control_reg <= SLIP_BUFFER_CONTROL_RST;
      receive_interface_control_reg <= RECEIVE_INTERFACE_CONTROL_RST;
      fifo_latency_setting_reg <= FIFO_LATENCY_SETTING_RST;
      mask_reg <= EVENT_MASK_RST[EV_COUNT-1:0];
    end else if (wr_i) begin
      unique case (addr_i)
        SLIP_BUFFER_CONTROL_ADDR: slip_buffer_control_reg <= wdata_i;
        RECEIVE_INTERFACE_CONTROL_ADDR: receive_interface_control_reg <= wdata_i;
        FIFO_LATENCY_SETTING_ADDR: fifo_latency_setting_reg <= wdata_i;
        EVENT_MASK_ADDR: mask_reg <= wdata_i[EV_COUNT-1:0];
        default: mask_reg <= mask_reg;
      endcase
    end
  end

  // Sticky events, write one to clear; a new event beats the clear
  always_comb begin
    status_next = status_reg;
    if (wr_i && addr_i == EVENT_STATUS_ADDR) begin
      status_next = status_reg & ~wdata_i[EV_COUNT-1:0];
    end
    status_next = status_next | events;
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      status_reg <= '0;
      irq_o <= 1'b0;
    end else begin
      status_reg <= status_next;
      irq_o <= |(status_reg & mask_reg);
    end
  end

  // Read data in the cycle after the strobe only
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_o <= ZERO_BYTE;
    end else if (rd_i) begin
      unique case (addr_i)
        SLIP_BUFFER_CONTROL_ADDR: rdata_o <= slip_buffer_control_reg;
        RECEIVE_INTERFACE_CONTROL_ADDR: rdata_o <= receive_interface_control_reg;
        FIFO_LATENCY_SETTING_ADDR: rdata_o <= fifo_latency_setting_reg;
        EVENT_STATUS_ADDR: rdata_o <= {{(DATA_W-EV_COUNT){1'b0}}, status_reg};
        EVENT_MASK_ADDR: rdata_o <= {{(DATA_W-EV_COUNT){1'b0}}, mask_reg};
        default: rdata_o <= ZERO_BYTE;
      endcase
    end else begin
      rdata_o <= ZERO_BYTE;
    end
  end
endmodule // ds1_rx_backplane_output

//--- ds1_rx_backplane_output_properties.sv
// Port-level assertions for the receive backplane output port
`timescale 1ns/10ps
module ds1_rx_backplane_output_chk
  import ds1_rx_pkg::*;
(
  // Clock, reset and register port
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [DATA_W-1:0] rdata_o,
  input wire logic irq_o,
  // Backplane pins
  input wire logic rx_backplane_clock_pin_o,
  input wire logic rx_backplane_clock_pin_oe_o,
  input wire logic rx_frame_sync_pin_o,
  input wire logic rx_frame_sync_pin_oe_o,
  input wire logic rx_multiframe_sync_pin_o,
  input wire logic rx_payload_serial_out_o
);
  logic [DATA_W-1:0] sb_reg;
  logic [DATA_W-1:0] ri_reg;
  logic byp;
  // Shadows rebuilt from bus writes, the registers are not visible here
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sb_reg <= SLIP_BUFFER_CONTROL_RST;
      ri_reg <= RECEIVE_INTERFACE_CONTROL_RST;
    end else if (wr_i && addr_i == SLIP_BUFFER_CONTROL_ADDR) begin
      sb_reg <= wdata_i;
    end else if (wr_i && addr_i == RECEIVE_INTERFACE_CONTROL_ADDR) begin
      ri_reg <= wdata_i;
    end
  end
  assign byp = sb_reg[1] == sb_reg[0];
  default clocking @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  property p_clk_oe;
    sb_reg == $past(sb_reg, 3) |-> rx_backplane_clock_pin_oe_o == byp;
  endproperty
  a_clk_oe: assert property (p_clk_oe) else $error("clock pin direction wrong");
  property p_sync_oe;
    sb_reg == $past(sb_reg, 3) |-> rx_frame_sync_pin_oe_o == (byp || !sb_reg[SB_SYNC_DIR_BIT]);
  endproperty
  a_sync_oe: assert property (p_sync_oe) else $error("sync pin direction wrong");
  property p_rd_idle;
    !$past(rd_i) |-> rdata_o == ZERO_BYTE;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
  property p_rd_sb;
    $past(rd_i) && $past(addr_i) == SLIP_BUFFER_CONTROL_ADDR |-> rdata_o == $past(sb_reg);
  endproperty
  a_rd_sb: assert property (p_rd_sb) else $error("slip control readback wrong");
  property p_rd_ri;
    $past(rd_i) && $past(addr_i) == RECEIVE_INTERFACE_CONTROL_ADDR |-> rdata_o == $past(ri_reg);
  endproperty
  a_rd_ri: assert property (p_rd_ri) else $error("interface control readback wrong");
  property p_irq_off;
    wr_i && addr_i == EVENT_MASK_ADDR && wdata_i == ZERO_BYTE |-> ##2 !irq_o;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("masked interrupt still high");
  property p_mf_sync;
    rx_frame_sync_pin_oe_o && $rose(rx_multiframe_sync_pin_o) |-> rx_frame_sync_pin_o;
  endproperty
  a_mf_sync: assert property (p_mf_sync) else $error("multiframe end off frame end");
  property p_data_edge;
    rx_backplane_clock_pin_oe_o && $past(rx_backplane_clock_pin_oe_o)
      && ($changed(rx_payload_serial_out_o) || $rose(rx_frame_sync_pin_o))
      |-> ($past(ri_reg[RI_CLK_INV_BIT]) ? $fell(rx_backplane_clock_pin_o)
           : $rose(rx_backplane_clock_pin_o));
  endproperty
  a_data_edge: assert property (p_data_edge) else $error("data change off clock edge");
endmodule // ds1_rx_backplane_output_chk

bind ds1_rx_backplane_output ds1_rx_backplane_output_chk ds1_rx_backplane_output_chk_inst (
  .clock_i, .nrst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .irq_o,
  .rx_backplane_clock_pin_o, .rx_backplane_clock_pin_oe_o, .rx_frame_sync_pin_o,
  .rx_frame_sync_pin_oe_o, .rx_multiframe_sync_pin_o, .rx_payload_serial_out_o
);

//--- ds1_terminal_model.sv
// Terminal equipment model: free-running serial clock and frame sync
`timescale 1ns/10ps
module ds1_terminal_model #(
  parameter int FRAME_BITS = 193
) (
  // Half period of the supplied clock in ns
  input wire logic [15:0] half_ns_i,
  // Pins toward the port
  output logic bclk_o,
  output logic fsync_o
);
  int bit_cnt = 0;
  initial begin
    bclk_o = 1'h0;
    fsync_o = 1'h0;
  end
  // Never stops, even across mode changes
  always begin
    #(half_ns_i) bclk_o = ~bclk_o;
  end
  always @(negedge bclk_o) begin
    fsync_o <= bit_cnt == 0;
    bit_cnt <= (bit_cnt == FRAME_BITS - 1) ? 0 : bit_cnt + 1;
  end
endmodule // ds1_terminal_model

//--- ds1_rx_backplane_output_tb.sv
// Self-checking bench for the receive backplane output port
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin miscompares++; \
  $display("[FAIL] %s exp %h got %h", nm, exp, got); end end
module ds1_rx_backplane_output_tb;
  import ds1_rx_pkg::*;
  localparam int FB = 193;
  localparam int CEIL = 90000;
  localparam int MF = 12;
  typedef struct packed {
    logic [7:0] a;
    logic [7:0] d;
    logic [7:0] r;
    logic co;
    logic so;
  } row_t;
  row_t rows [11] = '{
    '{8'h16, 8'h00, 8'h00, 1'h1, 1'h1}, '{8'h16, 8'h03, 8'h03, 1'h1, 1'h1},
    '{8'h16, 8'h07, 8'h07, 1'h1, 1'h1}, '{8'h16, 8'h01, 8'h01, 1'h0, 1'h1},
    '{8'h16, 8'h05, 8'h05, 1'h0, 1'h0}, '{8'h16, 8'h06, 8'h06, 1'h0, 1'h0},
    '{8'h16, 8'h02, 8'h02, 1'h0, 1'h1}, '{8'h22, 8'h08, 8'h08, 1'h0, 1'h1},
    '{8'h24, 8'h80, 8'h80, 1'h0, 1'h1}, '{8'h31, 8'h0C, 8'h0C, 1'h0, 1'h1},
    '{8'h40, 8'hAA, 8'h00, 1'h0, 1'h1}};
  logic [7:0] ra [5] = '{8'h16, 8'h22, 8'h24, 8'h30, 8'h31};
  logic [7:0] rv [5] = '{SLIP_BUFFER_CONTROL_RST, RECEIVE_INTERFACE_CONTROL_RST,
    FIFO_LATENCY_SETTING_RST, ZERO_BYTE, EVENT_MASK_RST};
  logic clock_i = 1'h0;
  logic nrst_i = 1'h0;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'h0;
  logic rd_i = 1'h0;
  logic [7:0] rdata_o;
  logic irq_o;
  logic recovered_clk_i = 1'h0;
  logic framer_data_i;
  logic framer_frame_i;
  logic rx_backplane_clock_pin_i;
  logic rx_backplane_clock_pin_o;
  logic rx_backplane_clock_pin_oe_o;
  logic rx_frame_sync_pin_i;
  logic rx_frame_sync_pin_o;
  logic rx_frame_sync_pin_oe_o;
  logic rx_multiframe_sync_pin_o;
  logic rx_payload_serial_out_o;
  logic te_clk;
  logic te_sync;
  logic [15:0] half = 16'h0144;
  logic [7:0] v;
  logic b;
  int n;
  int lbit = 0;
  int cyc = 0;
  int n_sync = 0;
  logic sync_q = 1'h0;
  int miscompares = 0;
  int n_compared = 0;
  always #4 clock_i = ~clock_i;
  always #62.5 recovered_clk_i = ~recovered_clk_i;
  // Framer bits change away from the sampling edge; only a frame's last bit is high
  always @(negedge recovered_clk_i) begin
    lbit <= (lbit == FB - 1) ? 0 : lbit + 1;
  end
  assign framer_data_i = lbit == FB - 1;
  assign framer_frame_i = lbit == 0;
  assign rx_backplane_clock_pin_i = rx_backplane_clock_pin_oe_o ? rx_backplane_clock_pin_o : te_clk;
  assign rx_frame_sync_pin_i = rx_frame_sync_pin_oe_o ? rx_frame_sync_pin_o : te_sync;
  ds1_rx_backplane_output ds1_rx_backplane_output_inst (
    .clock_i, .nrst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .irq_o,
    .recovered_clk_i, .framer_data_i, .framer_frame_i, .rx_backplane_clock_pin_i,
    .rx_backplane_clock_pin_o, .rx_backplane_clock_pin_oe_o, .rx_frame_sync_pin_i,
    .rx_frame_sync_pin_o, .rx_frame_sync_pin_oe_o, .rx_multiframe_sync_pin_o,
    .rx_payload_serial_out_o);
  ds1_terminal_model ds1_terminal_model_inst (.half_ns_i(half), .bclk_o(te_clk), .fsync_o(te_sync));
  task automatic close_out;
    if (miscompares == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (cyc == CEIL) begin
      miscompares++;
      close_out;
    end
  end
  // Frame ends between multiframe ends, sampled away from the launching edge
  always @(negedge clock_i) begin
    sync_q <= rx_frame_sync_pin_o;
    if (!nrst_i) begin
      n_sync <= 0;
    end else if (rx_frame_sync_pin_o && !sync_q) begin
      n_sync <= rx_multiframe_sync_pin_o ? 0 : n_sync + 1;
      if (rx_multiframe_sync_pin_o) `CHK("frames per multiframe", MF - 1, n_sync)
    end
  end
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'h1;
    @(posedge clock_i);
    wr_i <= 1'h0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock_i);
    addr_i <= a;
    rd_i <= 1'h1;
    @(posedge clock_i);
    rd_i <= 1'h0;
    #1 d = rdata_o;
  endtask
  // Bits counted as clock rises between two frame-end pulses
  task automatic frame_len(output int cnt, output logic last);
    logic pc;
    logic ps;
    @(posedge rx_frame_sync_pin_o);
    #1 last = rx_payload_serial_out_o;
    cnt = 0;
    do begin
      ps = rx_frame_sync_pin_o;
      pc = rx_backplane_clock_pin_o;
      @(posedge clock_i);
      #1 if (rx_backplane_clock_pin_o && !pc) cnt++;
    end while (!(rx_frame_sync_pin_o && !ps));
  endtask
  task automatic slip_check(input logic [7:0] m);
    int t;
    t = 0;
    while (irq_o !== 1'h1 && t < 30000) begin
      @(posedge clock_i);
      t++;
    end
    rd_reg(EVENT_STATUS_ADDR, v);
    `CHK("slip flag", m, v & m)
    wr_reg(EVENT_STATUS_ADDR, m);
    rd_reg(EVENT_STATUS_ADDR, v);
    `CHK("flag cleared", ZERO_BYTE, v & m)
    wr_reg(EVENT_MASK_ADDR, ZERO_BYTE);
    repeat (2) @(posedge clock_i);
    #1 `CHK("irq masked", 1'h0, irq_o)
  endtask
  initial begin
    repeat (20) @(posedge clock_i);
    nrst_i <= 1'h1;
    foreach (rows[i]) begin
      wr_reg(rows[i].a, rows[i].d);
      repeat (2) @(posedge clock_i);
      #1 `CHK("clock oe", rows[i].co, rx_backplane_clock_pin_oe_o)
      `CHK("sync oe", rows[i].so, rx_frame_sync_pin_oe_o)
      rd_reg(rows[i].a, v);
      `CHK("readback", rows[i].r, v)
    end
    @(posedge clock_i);
    nrst_i <= 1'h0;
    repeat (20) @(posedge clock_i);
    nrst_i <= 1'h1;
    foreach (ra[i]) begin
      rd_reg(ra[i], v);
      `CHK("reset value", rv[i], v)
    end
    `CHK("reset clock oe", 1'h1, rx_backplane_clock_pin_oe_o)
    for (int k = 0; k < 2; k++) begin
      wr_reg(RECEIVE_INTERFACE_CONTROL_ADDR, k ? 8'h08 : 8'h00);
      frame_len(n, b);
      frame_len(n, b);
      `CHK("frame bits", FB, n)
      `CHK("last bit", 1'h1, b)
    end
    @(posedge rx_multiframe_sync_pin_o);
    #1 `CHK("multiframe at frame end", 1'h1, rx_frame_sync_pin_o)
    wr_reg(RECEIVE_INTERFACE_CONTROL_ADDR, 8'h00);
    wr_reg(EVENT_MASK_ADDR, 8'h02);
    wr_reg(SLIP_BUFFER_CONTROL_ADDR, 8'h01);
    slip_check(8'h02);
    half <= 16'h0032;
    wr_reg(EVENT_MASK_ADDR, 8'h01);
    slip_check(8'h01);
    close_out;
  end
endmodule // ds1_rx_backplane_output_tb
